// ===== rtl/serial_baud_generator.sv
/*
  Baud rate generator and receive-line majority sampler for a serial port,
  with a classic Wishbone register slave.
  Assumes clk is the core clock of the device and srst the port reset.
*/
// Behaviour
// - Bit timing is derived only from the core clock clk.
// - Receive pin sampled three times; level decided by majority vote.
// - Async, high speed clear: rate is clock over 64 times divisor plus one.
// - Async, high speed set: rate is clock over 16 times divisor plus one.
// - Sync mode: bit clock is clock over 4 times divisor plus one.
// - Divisor comes straight from the 8-bit baud divisor register.
// - Writing the divisor register clears the rate timer at once.
// - High speed select is ignored in synchronous mode.
module serial_baud_generator
    import baud_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        serial_in_pin,
    output logic             bit_clock,
    output logic             rx_sample_level,
    output logic             rx_sample_valid
);

    // ----------------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------------
    logic [7:0]           tx_control_status_r;
    logic [7:0]           rx_control_status_r;
    logic [DIV_WIDTH-1:0] baud_divisor_r;
    logic [5:0]           prescale_r;
    logic [5:0]           prescale_nxt;
    logic [3:0]           phase_r;
    logic                 sampled_level;
    logic                 sampled_valid;
    logic                 timer_tick;
    wb_req_t              req;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------
    // A request is taken once; the ack cycle blocks a second take.
    wire access     = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
    wire hit_tx     = (req.adr == OFS_TX_CONTROL_STATUS);
    wire hit_rx     = (req.adr == OFS_RX_CONTROL_STATUS);
    wire hit_div    = (req.adr == OFS_BAUD_DIVISOR);
    wire hit_stat   = (req.adr == OFS_RATE_STATUS);
    wire mapped     = hit_tx || hit_rx || hit_div || hit_stat;
    wire wr_lane0   = access && req.we && req.sel[0];
    wire wr_tx      = wr_lane0 && hit_tx;
    wire wr_rx      = wr_lane0 && hit_rx;
    wire wr_div     = wr_lane0 && hit_div;

    // ----------------------------------------------------------------------
    // Mode selection
    // ----------------------------------------------------------------------
    wire port_enabled = rx_control_status_r[RX_PORT_EN_BIT];
    wire sync_mode    = tx_control_status_r[TX_SYNC_BIT];
    wire high_speed   = tx_control_status_r[TX_HIGH_SPEED_BIT];

    // Synchronous mode does not look at the high speed select at all.
    wire [5:0] prescale_top = sync_mode ? PRESCALE_SYNC
                            : high_speed ? PRESCALE_ASYNC_HIGH
                            : PRESCALE_ASYNC_LOW;

    // Clear the whole rate chain on divisor writes or while the port is off.
    wire chain_clear = wr_div || !port_enabled;

    // ----------------------------------------------------------------------
    // Divisor timer: one tick every divisor plus one core clocks
    // ----------------------------------------------------------------------
    // Running on the core clock means any clock switch changes the rate; the
    // divisor must then be rewritten by software.
    rate_timer #(
        .WIDTH (DIV_WIDTH)
    ) u_rate_timer (
        .clk        (clk),
        .srst       (srst),
        .clear      (chain_clear),
        .enable     (port_enabled),
        .load_value (baud_divisor_r),
        .tick       (timer_tick)
    );

    // ----------------------------------------------------------------------
    // Prescaler and bit clock
    // ----------------------------------------------------------------------
    // The prescaler counts timer ticks; wrapping at the top gives the fixed
    // 4, 16 or 64 factor. The bit clock is a one-cycle pulse per bit.
    wire prescale_wrap = timer_tick && (prescale_r >= prescale_top);
    assign prescale_nxt = chain_clear ? 6'h00
                        : prescale_wrap ? 6'h00
                        : timer_tick ? prescale_r + 6'h01
                        : prescale_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            prescale_r <= 6'h00;
            bit_clock  <= 1'b0;
        end else begin
            prescale_r <= prescale_nxt;
            bit_clock  <= prescale_wrap && !chain_clear;
        end
    end

    // ----------------------------------------------------------------------
    // Receive sampling phase
    // ----------------------------------------------------------------------
    // Sixteen sampling phases per bit in async high speed mode; each timer tick advances
    // the phase. Samples sit in the middle of the bit where edges are far off.
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r <= 4'h0;
        end else if (chain_clear) begin
            phase_r <= 4'h0;
        end else if (timer_tick) begin
            phase_r <= phase_r + 4'h1;
        end
    end

    wire take_a = timer_tick && (phase_r == SAMPLE_PHASE_A);
    wire take_b = timer_tick && (phase_r == SAMPLE_PHASE_B);
    wire take_c = timer_tick && (phase_r == SAMPLE_PHASE_C);

    majority_sampler u_majority_sampler (
        .clk         (clk),
        .srst        (srst),
        .pin         (serial_in_pin),
        .take_a      (take_a),
        .take_b      (take_b),
        .take_c      (take_c),
        .level       (sampled_level),
        .level_valid (sampled_valid)
    );

    // Outputs are re-registered so every top output comes from a flip-flop.
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_sample_level <= 1'b1;
            rx_sample_valid <= 1'b0;
        end else begin
            rx_sample_level <= sampled_level;
            rx_sample_valid <= sampled_valid;
        end
    end

    // ----------------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------------
    // Shift-idle stays set: this block has no transmitter behind it.
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_control_status_r <= TX_CONTROL_RESET;
            rx_control_status_r <= RX_CONTROL_RESET;
            baud_divisor_r      <= DIVISOR_RESET;
        end else begin
            if (wr_tx) begin
                tx_control_status_r <= (req.dat[7:0] & TX_WRITE_MASK)
                                     | TX_CONTROL_RESET;
            end
            if (wr_rx) begin
                rx_control_status_r <= req.dat[7:0] & RX_WRITE_MASK;
            end
            if (wr_div) begin
                baud_divisor_r <= req.dat[DIV_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------------
    // Read data and answer
    // ----------------------------------------------------------------------
    // Status word shows the live prescale count and timer activity.
    wire [31:0] status_word = {22'h000000, sampled_level, port_enabled,
                               prescale_r, timer_tick, sync_mode};
    wire [31:0] read_word = hit_tx   ? {24'h000000, tx_control_status_r}
                          : hit_rx   ? {24'h000000, rx_control_status_r}
                          : hit_div  ? {{(32 - DIV_WIDTH){1'b0}}, baud_divisor_r}
                          : hit_stat ? status_word
                          : 32'h00000000;

    // One wait-free answer: ack or err the cycle after the request is taken.
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= access && mapped;
            wb_err_o <= access && !mapped;
            wb_dat_o <= (access && !req.we) ? read_word : 32'h00000000;
        end
    end

endmodule // serial_baud_generator

// ===== inc/baud_pkg.sv
/*
  Package for the serial baud generator: register offsets, field positions,
  reset values and divide constants.
  Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
*/
package baud_pkg;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam logic [7:0] OFS_TX_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] OFS_RX_CONTROL_STATUS = 8'h04;
    localparam logic [7:0] OFS_BAUD_DIVISOR      = 8'h08;
    localparam logic [7:0] OFS_RATE_STATUS       = 8'h0c;

    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int TX_SYNC_BIT       = 4;
    localparam int TX_HIGH_SPEED_BIT = 2;
    localparam int TX_SHIFT_IDLE_BIT = 1;
    localparam int RX_PORT_EN_BIT    = 7;

    // Writable masks; other bits read as stored zero or hardware state.
    localparam logic [7:0] TX_WRITE_MASK = 8'hf5;
    localparam logic [7:0] RX_WRITE_MASK = 8'hf8;

    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [7:0] TX_CONTROL_RESET = 8'h02;
    localparam logic [7:0] RX_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DIVISOR_RESET    = 8'h00;

    // ----------------------------------------------------------------------
    // Prescale ratios applied after the divisor timer
    // ----------------------------------------------------------------------
    localparam logic [5:0] PRESCALE_ASYNC_LOW  = 6'h3f;  // Divide by 64.
    localparam logic [5:0] PRESCALE_ASYNC_HIGH = 6'h0f;  // Divide by 16.
    localparam logic [5:0] PRESCALE_SYNC       = 6'h03;  // Divide by 4.

    // Sample points inside a 16-phase bit window for the majority vote.
    localparam logic [3:0] SAMPLE_PHASE_A = 4'h7;
    localparam logic [3:0] SAMPLE_PHASE_B = 4'h8;
    localparam logic [3:0] SAMPLE_PHASE_C = 4'h9;

    // Bus request bundle.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// ===== rtl/rate_timer.sv
/*
  Down-counting rate timer: loads a terminal value, ticks at zero, reloads.
  Assumes a synchronous active-high reset and a clear input from the owner.
*/
module rate_timer
    import baud_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             clear,
    input  wire logic             enable,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  tick
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    wire              at_zero = (count_r == '0);

    // Reload on zero so the period is load_value plus one enabled cycles.
    // A clear empties the count rather than loading it: the value on
    // load_value is still the old one in the clear cycle, and loading it
    // would make the new rate wait out a full old period.
    assign count_nxt = clear ? '0
                     : (!enable) ? count_r
                     : at_zero ? load_value
                     : count_r - 1'b1;

    // Tick is a one-cycle pulse, or stays high every enabled cycle while load_value is zero; a clear suppresses it so no stale tick escapes.
    always_ff @(posedge clk) begin
        if (srst) begin
            count_r <= '0;
            tick    <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick    <= enable && at_zero && !clear;
        end
    end

endmodule // rate_timer

// ===== rtl/majority_sampler.sv
/*
  Three-sample majority voter for the receive pin.
  Assumes the pin is synchronous to clk and sample strobes are single pulses.
*/
module majority_sampler
    import baud_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin,
    input  wire logic take_a,
    input  wire logic take_b,
    input  wire logic take_c,
    output logic      level,
    output logic      level_valid
);

    logic s_a_r;
    logic s_b_r;

    // The vote uses the two stored samples and the live third one.
    wire vote = (s_a_r & s_b_r) | (s_a_r & pin) | (s_b_r & pin);

    // Idle line is high, so the voted level resets high.
    always_ff @(posedge clk) begin
        if (srst) begin
            s_a_r       <= 1'b1;
            s_b_r       <= 1'b1;
            level       <= 1'b1;
            level_valid <= 1'b0;
        end else begin
            if (take_a) s_a_r <= pin;
            if (take_b) s_b_r <= pin;
            if (take_c) level <= vote;
            level_valid <= take_c;
        end
    end

endmodule // majority_sampler

// ===== sim/serial_baud_generator_chk.sv
/*
  Checker for the serial baud generator: bus handshake, pulse shapes,
  divisor-write clear and vote timing, seen only at the top ports.
  Assumes one clock domain and the synchronous active-high reset srst.
*/
module serial_baud_generator_chk
    import baud_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        serial_in_pin,
    input wire logic        bit_clock,
    input wire logic        rx_sample_level,
    input wire logic        rx_sample_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // A request is taken only while no answer is out, as the slave sees it.
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // ----------------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------------
    sequence div_write;
        take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_BAUD_DIVISOR;
    endsequence
    sequence quiet_pair;
        !bit_clock [*2];
    endsequence

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    a_bus_answer: assert property (take |=> wb_ack_o != wb_err_o)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_tick_spacing: assert property (bit_clock |=> !bit_clock [*3])
        else $error("bit clock pulses closer than four cycles");
    a_div_clear: assert property (div_write |-> ##2 quiet_pair)
        else $error("bit clock right after divisor write");
    a_vote_spacing: assert property (rx_sample_valid |=> !rx_sample_valid [*8])
        else $error("votes closer than the sample window");
    // Reset forces the level high, so a move right after reset is no vote.
    a_level_on_vote: assert property ($changed(rx_sample_level)
        |-> rx_sample_valid || $past(srst))
        else $error("voted level moved without a vote");
endmodule // serial_baud_generator_chk

bind serial_baud_generator serial_baud_generator_chk chk_i (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .serial_in_pin(serial_in_pin), .bit_clock(bit_clock),
    .rx_sample_level(rx_sample_level), .rx_sample_valid(rx_sample_valid));

// ===== sim/rx_line_model.sv
/*
  Far-side serial source: holds the receive line at a level and can invert
  it for single cycles. Assumes the bench moves its controls after edges.
*/
module rx_line_model (
    input  wire logic level,
    input  wire logic glitch,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // A glitch flips the line so that exactly one sample point may be wrong.
    assign pin = glitch ? ~level : level;
endmodule // rx_line_model

// ===== sim/tb_top.sv
/*
  Testbench for the serial baud generator: register map, divide ratios,
  divisor clear, port enable, majority vote and reset.
  Assumes a 125 MHz clock and the one-cycle Wishbone answer of the slave.
*/
module tb_top;
    import baud_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        sync;
        logic        hs;
        logic [7:0]  div;
        logic [31:0] per;
    } row_t;

    logic        clk, srst, level, glitch, pin, bit_clock, lvl_o, vld_o, ack, err, e;
    logic [31:0] rdat, q;
    logic [3:0]  wsel = 4'hf;
    wb_req_t     req;
    int          num_errors, n_checks, cycles, p;
    // Period is K times divisor plus one; high speed must not matter in sync.
    row_t rows[7] = '{'{1'b1, 1'b0, 8'h00, 32'h4}, '{1'b1, 1'b1, 8'h00, 32'h4},
                      '{1'b0, 1'b1, 8'h00, 32'h10}, '{1'b0, 1'b0, 8'h00, 32'h40},
                      '{1'b0, 1'b0, 8'h01, 32'h80}, '{1'b0, 1'b1, 8'h02, 32'h30},
                      '{1'b1, 1'b0, 8'hff, 32'h400}};

    serial_baud_generator dut (.clk(clk), .srst(srst), .wb_cyc_i(req.cyc),
        .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr),
        .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .serial_in_pin(pin), .bit_clock(bit_clock), .rx_sample_level(lvl_o),
        .rx_sample_valid(vld_o));
    rx_line_model line_i (.level(level), .glitch(glitch), .pin(pin));

    // ----------------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request stands until ack or err is sampled.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        req <= '{1'b1, 1'b1, we, wsel, a, d};
        @(posedge clk);
        while (!(ack || err))
            @(posedge clk);
        q = rdat;
        e = err;
        req <= '0;
        @(posedge clk);
    endtask

    // Counts edges to the next pulse of bit_clock or of the vote strobe.
    task automatic gap(input bit vote, output int n);
        n = 1;
        @(posedge clk);
        while ((vote ? vld_o : bit_clock) !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if ((vote ? vld_o : bit_clock) !== 1'b1)
            num_errors++;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // A hang ends the run well past the few thousand cycles it needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        req = '0;
        level = 1'b1;
        glitch = 1'b0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        wb(1'b0, OFS_TX_CONTROL_STATUS, 32'h0);
        chk(q, {24'h0, TX_CONTROL_RESET});
        wb(1'b0, OFS_BAUD_DIVISOR, 32'h0);
        chk(q, {24'h0, DIVISOR_RESET});
        wb(1'b0, 8'h10, 32'h0);
        chk(32'(e), 32'h1);
        wb(1'b1, OFS_TX_CONTROL_STATUS, 32'hff);
        wb(1'b0, OFS_TX_CONTROL_STATUS, 32'h0);
        chk(q, 32'hf7);
        $display("test registers done");
        wb(1'b1, OFS_RX_CONTROL_STATUS, 32'h80);
        foreach (rows[k]) begin
            wb(1'b1, OFS_TX_CONTROL_STATUS, {27'h0, rows[k].sync, 1'b0, rows[k].hs, 2'h0});
            wb(1'b1, OFS_BAUD_DIVISOR, {24'h0, rows[k].div});
            gap(1'b0, p);
            gap(1'b0, p);
            gap(1'b0, p);
            chk(32'(p), rows[k].per);
        end
        $display("test ratios done");
        // Mid-count divisor write: the new rate must not wait for the old count.
        repeat (300) @(posedge clk);
        wb(1'b1, OFS_BAUD_DIVISOR, 32'h0);
        gap(1'b0, p);
        chk(32'(p <= 8), 32'h1);
        wb(1'b1, OFS_RX_CONTROL_STATUS, 32'h0);
        p = 0;
        repeat (100) begin
            @(posedge clk);
            if (bit_clock === 1'b1)
                p++;
        end
        chk(32'(p), 32'h0);
        wb(1'b0, OFS_RATE_STATUS, 32'h0);
        chk(q, 32'h201);
        // A write without byte lane 0 is acknowledged but must not land.
        wsel = 4'he;
        wb(1'b1, OFS_BAUD_DIVISOR, 32'h77);
        wsel = 4'hf;
        wb(1'b0, OFS_BAUD_DIVISOR, 32'h0);
        chk(q, 32'h0);
        $display("test clear and disable done");
        wb(1'b1, OFS_RX_CONTROL_STATUS, 32'h80);
        wb(1'b1, OFS_TX_CONTROL_STATUS, 32'h10);
        level <= 1'b0;
        gap(1'b1, p);
        gap(1'b1, p);
        chk(32'(lvl_o), 32'h0);
        level <= 1'b1;
        gap(1'b1, p);
        gap(1'b1, p);
        chk(32'(lvl_o), 32'h1);
        // A lone wrong sample at every phase must be outvoted.
        for (int k = 0; k < 16; k++) begin
            gap(1'b1, p);
            repeat (k) @(posedge clk);
            glitch <= 1'b1;
            @(posedge clk);
            glitch <= 1'b0;
            gap(1'b1, p);
            chk(32'(lvl_o), 32'h1);
        end
        $display("test vote done");
        // Leave a low level and a non-reset divisor so reset has work to do.
        level <= 1'b0;
        gap(1'b1, p);
        gap(1'b1, p);
        chk(32'(lvl_o), 32'h0);
        wb(1'b1, OFS_BAUD_DIVISOR, 32'h5a);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(32'(lvl_o), 32'h1);
        chk(32'({bit_clock, vld_o, ack, err}), 32'h0);
        level <= 1'b1;
        wb(1'b0, OFS_BAUD_DIVISOR, 32'h0);
        chk(q, {24'h0, DIVISOR_RESET});
        wb(1'b0, OFS_TX_CONTROL_STATUS, 32'h0);
        chk(q, {24'h0, TX_CONTROL_RESET});
        wb(1'b0, OFS_RX_CONTROL_STATUS, 32'h0);
        chk(q, {24'h0, RX_CONTROL_RESET});
        $display("test reset done");
        close_out();
    end
endmodule // tb_top
